// *** bench/fsf_fw_model.sv ***
// Firmware-side model that drains request bytes and supplies reply bytes.
`timescale 1ns/1ps
`default_nettype none
module fsf_fw_model
    import fsf_pkg::*;
#(
    parameter int REPLY_N = 4
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Bench controls.
    input wire logic drainEn,
    input wire logic holdExec,
    // Queue ports.
    output logic fwRequestReady,
    output fsf_byte_t fwReply,
    input wire logic fwReplyReady,
    // Command control.
    input wire logic fwExecStart,
    input wire logic fwAbort,
    input wire logic fwResend,
    output logic fwExecDone
);
    logic pend;
    logic [7:0] idx;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fwRequestReady <= 1'b0;
            fwReply <= '0;
            fwExecDone <= 1'b0;
            pend <= 1'b0;
            idx <= 8'h00;
        end else begin
            fwRequestReady <= drainEn;
            fwExecDone <= 1'b0;
            if (fwReply.valid && fwReplyReady) begin
                if (idx == 8'(REPLY_N - 1)) begin
                    fwReply.valid <= 1'b0;
                    fwReply.data <= ~fwReply.data;
                    pend <= 1'b0;
                    fwExecDone <= 1'b1;
                end else begin
                    fwReply.data <= 8'ha1 + idx;
                    idx <= idx + 8'h01;
                end
            end else if (pend && !holdExec && !fwReply.valid) begin
                fwReply.valid <= 1'b1;
                fwReply.data <= 8'ha0;
            end
            if (fwExecStart || fwResend) begin
                pend <= 1'b1;
                idx <= 8'h00;
            end
            if (fwAbort) begin
                pend <= 1'b0;
                fwReply.valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_fifo_status_flow_control.sv ***
// Self-checking testbench for the status and flow-control block.
`timescale 1ns/1ps
`default_nettype none
module tb_fifo_status_flow_control;
    import fsf_pkg::*;
    localparam int DEPTH = 300;
    localparam int NREP = 4;
    logic mclk, rst_n, initEv, strap, cyc, stb, we, drainEn, holdExec, ack;
    logic fwReplyReady, execStart, abortP, resendP, execDone, reqReady;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, rd;
    fsf_byte_t fwRequest, fwReply;
    fsf_state_t ifState;
    int nFail = 0;
    int totalChecks = 0;
    int cycles = 0;

    fsf_status_top #(.DEPTH(DEPTH), .FIXED(FIXED_ALLOW), .AW(4)) DUT (.mclk(mclk),
        .rst_n(rst_n), .moduleInitEvent(initEv), .allowanceFixedStrap(strap), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .fwRequest(fwRequest), .fwRequestReady(reqReady), .fwReply(fwReply),
        .fwReplyReady(fwReplyReady), .fwExecStart(execStart), .fwAbort(abortP),
        .fwResend(resendP), .fwExecDone(execDone), .ifState(ifState));
    fsf_fw_model #(.REPLY_N(NREP)) fw (.mclk(mclk), .rst_n(rst_n), .drainEn(drainEn),
        .holdExec(holdExec), .fwRequestReady(reqReady), .fwReply(fwReply),
        .fwReplyReady(fwReplyReady), .fwExecStart(execStart), .fwAbort(abortP),
        .fwResend(resendP), .fwExecDone(execDone));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic closeOut;
        if (nFail == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            nFail++;
            closeOut;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
        input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask

    function automatic logic [31:0] sts(input logic [15:0] al, input logic acc, av, ex);
        return {8'h00, al, 1'b1, acc, 1'b0, av, ex, 3'b000};
    endfunction

    task automatic rdSts(input string what, input logic [31:0] exp);
        wb(1'b0, ADDR_STATUS, 4'hf, ZERO_WORD);
        chk(what, exp, rd);
    endtask

    task automatic wrSts(input logic [7:0] v);
        wb(1'b1, ADDR_STATUS, 4'h1, {24'h0, v});
    endtask

    task automatic wrBytes(input int n);
        for (int i = 0; i < n; i++) wb(1'b1, ADDR_DATA, 4'h1, 32'h11);
    endtask

    task automatic waitSt(input fsf_state_t s);
        for (int n = 0; n < 300 && ifState !== s; n++) @(posedge mclk);
        chk("state", 32'(s), 32'(ifState));
    endtask

    task automatic tReset;
        waitSt(IF_IDLE);
        rdSts("idle status", sts(16'h0, 1'b0, 1'b0, 1'b0));
        wb(1'b0, ADDR_CAPS, 4'hf, ZERO_WORD);
        chk("caps dynamic", 32'h0, rd);
        wb(1'b0, 4'hc, 4'hf, ZERO_WORD);
        chk("unmapped", 32'h0, rd);
    endtask

    task automatic tAccept;
        wrSts(8'h00);
        waitSt(IF_IDLE);
        wrSts(8'h40);
        waitSt(IF_READY);
        rdSts("ready status", sts(16'(DEPTH), 1'b1, 1'b0, 1'b0));
        wrSts(8'h40);
        waitSt(IF_READY);
    endtask

    task automatic tSend;
        wrBytes(45);
        wb(1'b0, ADDR_STATUS, 4'h2, ZERO_WORD);
        chk("low snapshot", sts(16'(DEPTH - 45), 1'b0, 1'b0, 1'b1), rd);
        drainEn <= 1'b1;
        for (int n = 0; n < 300 && fwRequest.valid !== 1'b0; n++) @(posedge mclk);
        wb(1'b0, ADDR_STATUS, 4'h4, ZERO_WORD);
        chk("held high byte", 32'h0, {24'h0, rd[23:16]});
        rdSts("drained", sts(16'(DEPTH), 1'b0, 1'b0, 1'b1));
    endtask

    task automatic tExec;
        wrSts(8'h20);
        waitSt(IF_COMPLETE);
        rdSts("reply ready", sts(16'(NREP), 1'b0, 1'b1, 1'b0));
        for (int i = 0; i < NREP; i++) begin
            wb(1'b0, ADDR_DATA, 4'h1, ZERO_WORD);
            chk("reply byte", 32'(8'ha0 + i), {24'h0, rd[7:0]});
            if (i == 0) rdSts("one read", sts(16'(NREP - 1), 1'b0, 1'b1, 1'b0));
        end
        wb(1'b0, ADDR_DATA, 4'h1, ZERO_WORD);
        chk("empty read", 32'hff, {24'h0, rd[7:0]});
        wrSts(8'h02);
        rd = ZERO_WORD;
        for (int n = 0; n < 50 && rd[STS_AVAIL_BIT] !== 1'b1; n++) begin
            wb(1'b0, ADDR_STATUS, 4'hf, ZERO_WORD);
        end
        chk("resend avail", 32'h1, 32'(rd[STS_AVAIL_BIT]));
        wb(1'b0, ADDR_DATA, 4'h1, ZERO_WORD);
        chk("resend byte", 32'ha0, {24'h0, rd[7:0]});
        wrSts(8'h40);
        waitSt(IF_READY);
        rdSts("after ack", sts(16'(DEPTH), 1'b1, 1'b0, 1'b0));
    endtask

    task automatic tAbort;
        wrBytes(1);
        waitSt(IF_RECEIVE);
        wrSts(8'h40);
        waitSt(IF_IDLE);
        wrSts(8'h40);
        waitSt(IF_READY);
        wrBytes(1);
        holdExec <= 1'b1;
        wrSts(8'h20);
        waitSt(IF_EXECUTE);
        wrSts(8'h40);
        waitSt(IF_IDLE);
        holdExec <= 1'b0;
    endtask

    task automatic tFixed;
        int t0;
        strap <= 1'b1;
        drainEn <= 1'b0;
        initEv <= 1'b1;
        repeat (4) @(posedge mclk);
        initEv <= 1'b0;
        repeat (6) @(posedge mclk);
        wb(1'b0, ADDR_CAPS, 4'hf, ZERO_WORD);
        chk("caps fixed", 32'h1, rd);
        wrSts(8'h40);
        waitSt(IF_READY);
        rdSts("fixed ready", sts(16'(FIXED_ALLOW), 1'b1, 1'b0, 1'b0));
        wrBytes(1);
        rdSts("fixed first", sts(16'h0, 1'b0, 1'b0, 1'b1));
        wrBytes(FIXED_ALLOW - 1);
        rdSts("fixed again", sts(16'(FIXED_ALLOW), 1'b0, 1'b0, 1'b1));
        wrBytes(DEPTH - FIXED_ALLOW);
        rdSts("fixed full", sts(16'h0, 1'b0, 1'b0, 1'b1));
        t0 = cycles;
        fork
            wrBytes(1);
            begin
                repeat (20) @(posedge mclk);
                drainEn <= 1'b1;
            end
        join
        chk("stalled write", 32'h1, 32'(cycles - t0 >= 20));
    endtask

    initial begin
        rst_n = 1'b0;
        initEv = 1'b0;
        strap = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h0;
        drainEn = 1'b0;
        holdExec = 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        tReset;
        tAccept;
        tSend;
        tExec;
        tAbort;
        tFixed;
        closeOut;
    end
endmodule
`default_nettype wire

// *** src/fsf_byte_queue.sv ***
// Byte queue with flush, used for the request and reply directions.
`timescale 1ns/1ps
`default_nettype none
module fsf_byte_queue
    import fsf_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // Clock, reset and flush.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side.
    input wire fsf_byte_t pushIn,
    output logic pushReady,
    // Drain side.
    output fsf_byte_t popOut,
    input wire logic popReady,
    // Occupancy.
    output logic [CW-1:0] count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } fsf_queue_state_t;

    fsf_queue_state_t s;
    fsf_queue_state_t next_s;
    logic doPush;
    logic doPop;

    assign pushReady = (s.cnt != FULL_COUNT);
    assign popOut = '{valid: (s.cnt != '0),
        data: s.mem[s.rp]};
    assign count = s.cnt;

    always_comb begin
        next_s = s;
        doPush = pushIn.valid && pushReady;
        doPop = popReady && popOut.valid;
        if (doPush) begin
            next_s.mem[s.wp] = pushIn.data;
            next_s.wp = (s.wp == LAST_SLOT) ? '0 : s.wp + 1'b1;
        end
        if (doPop) begin
            next_s.rp = (s.rp == LAST_SLOT) ? '0 : s.rp + 1'b1;
        end
        if (doPush && !doPop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (doPop && !doPush) begin
            next_s.cnt = s.cnt - 1'b1;
        end
        if (flush) begin
            next_s.wp = '0;
            next_s.rp = '0;
            next_s.cnt = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// *** src/fsf_pkg.sv ***
// Shared constants and types for the FIFO status and flow-control block.
package fsf_pkg;
    // Register byte offsets on the bus.
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h4;
    localparam logic [3:0] ADDR_CAPS = 4'h8;
    // Status word bit positions.
    localparam int STS_RESEND_BIT = 1;
    localparam int STS_EXPECT_BIT = 3;
    localparam int STS_AVAIL_BIT = 4;
    localparam int STS_GO_BIT = 5;
    localparam int STS_ACCEPT_BIT = 6;
    localparam int STS_VALID_BIT = 7;
    localparam int ALLOW_LSB = 8;
    localparam int ALLOW_W = 16;
    // Capability word bit positions.
    localparam int CAPS_FIXED_BIT = 0;
    // Defaults and fill values.
    localparam int QUEUE_DEPTH = 64;
    localparam int FIXED_ALLOW = 16;
    localparam logic [7:0] EMPTY_READ = 8'hff;
    localparam logic [31:0] ZERO_WORD = 32'h0;

    typedef enum logic [2:0] {
        IF_IDLE,
        IF_READY,
        IF_RECEIVE,
        IF_EXECUTE,
        IF_COMPLETE
    } fsf_state_t;

    // One byte with its valid qualifier.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fsf_byte_t;
endpackage

// *** src/fsf_status_top.sv ***
// Status word, transfer allowance and interface state machine with its data queues.
// How it works
// RULE1: Allowance reads zero whenever the queue cannot move bytes without wait states.
// RULE2: Dynamic send allowance is free request space, down on host write, up on drain.
// RULE3: Dynamic read allowance is reply bytes held, down on host read, up on fill.
// RULE4: Fixed send allowance drops to zero on first byte until the fixed count arrives.
// RULE5: Fixed read allowance drops to zero on first read until the fixed count is read.
// RULE6: The fixed allowance value never changes between two module init events.
// RULE7: Host treats earlier allowance as stale after resend or abort until data available.
// RULE8: After accept flag sets, allowance becomes nonzero within the short timeout.
// RULE9: After response available sets, allowance becomes nonzero within the short timeout.
// RULE10: A split two-byte allowance read returns both bytes of one snapshot.
// RULE11: Status valid returns within the short timeout after a status write.
// RULE12: Status valid is only set while expect and available flags are correct.
// RULE13: Accept flag reads one exactly in Ready, entered only with both queues empty.
// RULE14: Accept flag clears when the first command byte enters the request queue.
// RULE15: A write of zero to the accept flag is ignored.
// RULE16: Writing one to the accept flag in Ready is ignored.
// RULE17: Writing one to the accept flag in Idle moves to Ready.
// RULE18: Writing one to the accept flag during reception aborts the command.
// RULE19: Writing one in completion flushes both queues and enters Ready.
// RULE20: Writing one during execution aborts the running command.
// RULE21: Host checks the accept flag and never sends data while it reads zero.
// RULE22: Host writes one to the accept flag after receiving a whole response.
// RULE23: A data write that cannot be taken is stalled, never dropped; code stalls only in Ready and Receive, acks and drops it elsewhere.
// RULE24: One explicit state register drives all flag updates.
`timescale 1ns/1ps
`default_nettype none
module fsf_status_top
    import fsf_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int FIXED = FIXED_ALLOW,
    parameter int AW = 4
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Asynchronous pins.
    input wire logic moduleInitEvent,
    input wire logic allowanceFixedStrap,
    // Wishbone classic slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [AW-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Firmware side of the queues.
    output fsf_byte_t fwRequest,
    input wire logic fwRequestReady,
    input wire fsf_byte_t fwReply,
    output logic fwReplyReady,
    // Firmware command control.
    output logic fwExecStart,
    output logic fwAbort,
    output logic fwResend,
    input wire logic fwExecDone,
    // Visible state.
    output fsf_state_t ifState
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [ALLOW_W-1:0] FIXED_VALUE = ALLOW_W'(FIXED);
    localparam logic [ALLOW_W-1:0] FIXED_LAST = ALLOW_W'(FIXED - 1);
    localparam logic [ALLOW_W-1:0] DEPTH_VALUE = ALLOW_W'(DEPTH);

    typedef struct packed {
        fsf_state_t st;
        logic ack;
        logic [31:0] rdData;
        logic status_valid_flag;
        logic [ALLOW_W-1:0] fixedLeft;
        logic [ALLOW_W-1:0] snap;
        logic snapValid;
        logic fixedMode;
        logic strapDone;
        logic execStart;
        logic abort;
        logic resend;
    } fsf_top_state_t;

    fsf_top_state_t s;
    fsf_top_state_t next_s;
    logic initSync;
    logic strapSync;
    logic [CW-1:0] reqCount;
    logic [CW-1:0] repCount;
    logic reqSpace;
    fsf_byte_t hostPush;
    fsf_byte_t hostPop;
    logic hostPopReady;
    logic flush;
    logic request;
    logic isStatus;
    logic isData;
    logic isCaps;
    logic sendPhase;
    logic readPhase;
    logic respAvail;
    logic expectMore;
    logic acceptFlag;
    logic [ALLOW_W-1:0] freeBytes;
    logic [ALLOW_W-1:0] heldBytes;
    logic [ALLOW_W-1:0] allowance;
    logic [ALLOW_W-1:0] allowShown;
    logic dataWrite;
    logic dataRead;
    logic stall;
    logic hostMoved;

    fsf_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .asyncIn({moduleInitEvent, allowanceFixedStrap}),
        .syncOut({initSync, strapSync})
    );

    fsf_byte_queue #(
        .DEPTH(DEPTH)
    ) u_request_queue (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(flush),
        .pushIn(hostPush),
        .pushReady(reqSpace),
        .popOut(fwRequest),
        .popReady(fwRequestReady),
        .count(reqCount)
    );

    fsf_byte_queue #(
        .DEPTH(DEPTH)
    ) u_reply_queue (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(flush),
        .pushIn(fwReply),
        .pushReady(fwReplyReady),
        .popOut(hostPop),
        .popReady(hostPopReady),
        .count(repCount)
    );

    // RULE13: accept flag mirrors the Ready state.
    assign acceptFlag = (s.st == IF_READY);
    assign sendPhase = (s.st == IF_READY) || (s.st == IF_RECEIVE);
    assign readPhase = (s.st == IF_COMPLETE);
    assign respAvail = readPhase && hostPop.valid;
    assign expectMore = (s.st == IF_RECEIVE);
    assign freeBytes = DEPTH_VALUE - ALLOW_W'(reqCount);
    assign heldBytes = ALLOW_W'(repCount);

    always_comb begin
        allowance = '0;
        if (!s.fixedMode) begin
            // RULE2: dynamic send count follows free request space.
            if (sendPhase) begin
                allowance = freeBytes;
            // RULE3: dynamic read count follows bytes held for the host.
            end else if (readPhase) begin
                allowance = heldBytes;
            end
        end else if (s.fixedLeft == '0) begin
            // RULE4: fixed send value only while a full burst fits.
            if (sendPhase && freeBytes >= FIXED_VALUE) begin
                allowance = FIXED_VALUE;
            // RULE5: fixed read value only while a full burst, or the tail, is held.
            end else if (readPhase && (heldBytes >= FIXED_VALUE
                    || (heldBytes != '0 && !fwReply.valid))) begin
                allowance = FIXED_VALUE;
            end
        end
    end

    assign request = cyc_i && stb_i && !s.ack;
    assign isStatus = (adr_i == AW'(ADDR_STATUS));
    assign isData = (adr_i == AW'(ADDR_DATA));
    assign isCaps = (adr_i == AW'(ADDR_CAPS));
    assign dataWrite = request && we_i && isData && sel_i[0];
    assign dataRead = request && !we_i && isData;
    // RULE23: in Ready or Receive a full request queue holds the bus instead of losing the byte.
    assign stall = dataWrite && sendPhase && !reqSpace;
    // RULE14: the first pushed byte is what leaves Ready.
    assign hostPush = '{valid: dataWrite && sendPhase && reqSpace,
        data: dat_i[7:0]};
    assign hostPopReady = dataRead && respAvail;
    assign hostMoved = hostPush.valid || hostPopReady;
    // RULE10: the upper byte alone reads the snapshot taken with the lower byte.
    assign allowShown = (!sel_i[1] && s.snapValid) ? s.snap : allowance;

    // RULE24: all flag updates derive from this one state register.
    always_comb begin
        next_s = s;
        flush = 1'b0;
        next_s.execStart = 1'b0;
        next_s.abort = 1'b0;
        next_s.resend = 1'b0;
        next_s.ack = request && !stall;
        next_s.rdData = ZERO_WORD;
        // RULE11: status valid returns the cycle after the write completes.
        next_s.status_valid_flag = 1'b1;
        if (request && !stall) begin
            if (isStatus && !we_i) begin
                next_s.rdData[ALLOW_LSB +: ALLOW_W] = allowShown;
                next_s.rdData[STS_VALID_BIT] = s.status_valid_flag;
                next_s.rdData[STS_ACCEPT_BIT] = acceptFlag;
                next_s.rdData[STS_AVAIL_BIT] = respAvail;
                next_s.rdData[STS_EXPECT_BIT] = expectMore;
                // RULE10: capture the count when its lower byte is read.
                if (sel_i[1]) begin
                    next_s.snap = allowance;
                    next_s.snapValid = 1'b1;
                end
            end else if (isCaps && !we_i) begin
                next_s.rdData[CAPS_FIXED_BIT] = s.fixedMode;
            end else if (dataRead) begin
                next_s.rdData[7:0] = respAvail ? hostPop.data : EMPTY_READ;
            end
        end
        if (request && isData) begin
            next_s.snapValid = 1'b0;
        end
        // RULE4: count host bytes of a fixed burst; zero shows meanwhile.
        if (s.fixedMode && hostMoved) begin
            next_s.fixedLeft = (s.fixedLeft == '0) ? FIXED_LAST : s.fixedLeft - 1'b1;
        end
        unique case (s.st)
            IF_READY: begin
                if (hostPush.valid) begin
                    next_s.st = IF_RECEIVE;
                end
            end
            IF_RECEIVE: begin
                if (request && we_i && isStatus && sel_i[0] && dat_i[STS_GO_BIT]) begin
                    next_s.st = IF_EXECUTE;
                    next_s.execStart = 1'b1;
                    next_s.fixedLeft = '0;
                end
            end
            IF_EXECUTE: begin
                if (fwExecDone) begin
                    next_s.st = IF_COMPLETE;
                end
            end
            IF_COMPLETE: begin
                if (request && we_i && isStatus && sel_i[0] && dat_i[STS_RESEND_BIT]) begin
                    flush = 1'b1;
                    next_s.resend = 1'b1;
                    next_s.fixedLeft = '0;
                end
            end
            IF_IDLE: begin
            end
        endcase
        if (request && we_i && isStatus) begin
            next_s.status_valid_flag = 1'b0;
            // RULE15: only a written one acts; a zero leaves state and queues alone.
            if (sel_i[0] && dat_i[STS_ACCEPT_BIT]) begin
                unique case (s.st)
                    // RULE16: already Ready, nothing changes.
                    IF_READY: begin
                    end
                    // RULE17: flush, then Ready on the next edge.
                    IF_IDLE: begin
                        flush = 1'b1;
                        next_s.st = IF_READY;
                    end
                    // RULE18: abort while receiving.
                    IF_RECEIVE: begin
                        flush = 1'b1;
                        next_s.abort = 1'b1;
                        next_s.st = IF_IDLE;
                    end
                    // RULE20: abort while executing.
                    IF_EXECUTE: begin
                        flush = 1'b1;
                        next_s.abort = 1'b1;
                        next_s.st = IF_IDLE;
                    end
                    // RULE19: both queues emptied, Ready reached at once.
                    IF_COMPLETE: begin
                        flush = 1'b1;
                        next_s.st = IF_READY;
                    end
                endcase
                next_s.fixedLeft = '0;
            end
        end
        // RULE6: the fixed-mode strap is sampled only at start and at init events.
        if (!s.strapDone) begin
            next_s.fixedMode = strapSync;
            next_s.strapDone = 1'b1;
        end
        if (initSync) begin
            flush = 1'b1;
            next_s.st = IF_IDLE;
            next_s.fixedLeft = '0;
            next_s.snapValid = 1'b0;
            next_s.strapDone = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{st: IF_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign dat_o = s.rdData;
    assign ack_o = s.ack;
    assign fwExecStart = s.execStart;
    assign fwAbort = s.abort;
    assign fwResend = s.resend;
    assign ifState = s.st;

    a_zero_no_room: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
        (sendPhase && !reqSpace) |-> (allowance == '0))
        else $error("allowance nonzero while request queue is full");
    a_dyn_send_count: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
        (!s.fixedMode && sendPhase) |-> (allowance == DEPTH_VALUE - ALLOW_W'(reqCount)))
        else $error("dynamic send allowance differs from free space");
    a_dyn_read_count: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
        (!s.fixedMode && readPhase) |-> (allowance == ALLOW_W'(repCount)))
        else $error("dynamic read allowance differs from held bytes");
    a_fixed_burst_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
        (s.fixedMode && s.fixedLeft != '0) |-> (allowance == '0))
        else $error("fixed allowance nonzero inside a burst");
    a_fixed_mode_stable: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
        (s.strapDone && !initSync) |=> $stable(s.fixedMode))
        else $error("fixed mode changed without an init event");
    a_accept_nonzero: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
        ($rose(acceptFlag) && !initSync) |-> ##[0:2] (allowance != '0 || !acceptFlag))
        else $error("allowance stayed zero after accept flag set");
    a_avail_nonzero: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
        ($rose(respAvail) && !s.fixedMode) |-> (allowance != '0))
        else $error("allowance zero while response available");
    a_split_read: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
        (request && isStatus && !we_i && sel_i[1]) |=> (s.snap == $past(allowance)))
        else $error("allowance snapshot not taken on lower byte read");
    a_valid_return: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
        (request && we_i && isStatus) |=> !s.status_valid_flag ##1 s.status_valid_flag)
        else $error("status valid not back one cycle after status write");
    a_ready_empty: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
        $rose(acceptFlag) |-> (reqCount == '0 && repCount == '0))
        else $error("Ready entered with a queue not empty");
    a_first_byte: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
        (acceptFlag && hostPush.valid && !initSync) |=> (s.st == IF_RECEIVE))
        else $error("accept flag did not clear on first byte");
    a_idle_to_ready: assert property (@(posedge mclk) disable iff (!rst_n) // RULE17
        (s.st == IF_IDLE && request && we_i && isStatus && sel_i[0]
            && dat_i[STS_ACCEPT_BIT] && !initSync) |=> (s.st == IF_READY))
        else $error("Idle did not move to Ready on accept write");
    a_write_stalled: assert property (@(posedge mclk) disable iff (!rst_n) // RULE23
        stall |=> !ack_o)
        else $error("data write acknowledged while request queue full");
endmodule
`default_nettype wire

// *** src/fsf_sync.sv ***
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module fsf_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Asynchronous input and its synchronised copy.
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } fsf_sync_state_t;

    fsf_sync_state_t s;
    fsf_sync_state_t next_s;

    always_comb begin
        next_s.first = asyncIn;
        next_s.second = s.first;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign syncOut = s.second;
endmodule
`default_nettype wire
